// ===== rtl/spc_pkg.sv
// Purpose: constants and types of the segment privilege checker
// Assumes: one core clock, Avalon-MM register access
// Notes: privilege levels are 2-bit, 0 most trusted
//
// Operation
// - Four levels, 0 most trusted, 3 least
// - Data access needs level at most segment level
// - Code segment called only from equal/lesser privilege
// - Current level changes only through gate transfers
// - Requested level is selector's low two bits
// - Effective level is max of current, requested
// - Port I/O free when current <= I/O field
// - Older task format: port I/O faults 13
// - Newer task format: bitmap allows or faults 13
// - Interrupt on/off fault 13; bus lock unchecked
// - Flags load changes interrupt flag only if allowed
// - Adjust-level takes max; zero flag if changed
// - Verify read/write set zero flag if allowed
// - Load-limit copies limit, zero flag if allowed
// - Load-rights copies rights byte if allowed
// - Data register load needs data or readable code
// - Readable conforming code exempt from level check
// - Effective more privileged than current faults 13
// - Stack load: writable data, levels equal current
// - Not present: stack faults 12, others 11
// - Virtual-8086 operation runs at level 3
package spc_pkg;

  // Register byte offsets
  localparam logic [7:0] SPC_OFF_CTRL = 8'h00;
  localparam logic [7:0] SPC_OFF_STATUS = 8'h04;
  localparam logic [7:0] SPC_OFF_SEG0 = 8'h10;
  localparam int SPC_NUM_SEG = 5;
  localparam int SPC_STACK_IDX = 4;

  // Control register fields
  localparam int SPC_CTRL_CPL_LSB = 0;
  localparam int SPC_CTRL_IO_PRIV_FIELD_LSB = 2;
  localparam int SPC_CTRL_IF_BIT = 4;
  localparam int SPC_CTRL_TSS32_BIT = 5;
  localparam int SPC_CTRL_V86_BIT = 6;

  // Status register fields
  localparam int SPC_STAT_FAULT_BIT = 8;
  localparam int SPC_STAT_ZF_BIT = 9;

  // Flags-image bit carrying the interrupt enable
  localparam int SPC_FLAGS_IF_BIT = 9;

  // Segment readback: selector low half, rights byte above
  localparam int SPC_SEG_AR_LSB = 16;

  // Descriptor type bits
  localparam int SPC_TYPE_CODE_BIT = 3;
  localparam int SPC_TYPE_CONF_BIT = 2;
  localparam int SPC_TYPE_RW_BIT = 1;

  // Reset values
  localparam logic [1:0] SPC_RST_CPL = 2'h0;
  localparam logic [1:0] SPC_RST_IO_PRIV_FIELD = 2'h0;
  localparam logic [1:0] SPC_LEVEL_V86 = 2'h3;

  // Exception vectors
  localparam logic [7:0] SPC_VEC_NONE = 8'h00;
  localparam logic [7:0] SPC_VEC_SEG_NP = 8'h0B;
  localparam logic [7:0] SPC_VEC_STACK = 8'h0C;
  localparam logic [7:0] SPC_VEC_GP = 8'h0D;

  typedef enum logic [3:0] {
    SPC_OP_NOP = 4'h0,
    SPC_OP_LOAD_DATA = 4'h1,
    SPC_OP_LOAD_STACK = 4'h2,
    SPC_OP_IO = 4'h3,
    SPC_OP_CLI = 4'h4,
    SPC_OP_STI = 4'h5,
    SPC_OP_LOCK = 4'h6,
    SPC_OP_FLAGS_LOAD = 4'h7,
    SPC_OP_ADJUST_REQUESTED_LEVEL_INSTR = 4'h8,
    SPC_OP_VERIFY_READ_INSTR = 4'h9,
    SPC_OP_VERIFY_WRITE_INSTR = 4'hA,
    SPC_OP_LSL = 4'hB,
    SPC_OP_LAR = 4'hC,
    SPC_OP_GATE = 4'hD,
    SPC_OP_CALL = 4'hE
  } spc_op_t;

endpackage : spc_pkg

// ===== rtl/spc_checker.sv
// Purpose: privilege checks for selector loads, I/O and pointer tests
// Assumes: requests come from logic on mclk; one request per cycle
// Notes: every answer appears one cycle after op_valid
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

module spc_checker
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Request from execution pipeline
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [1:0] op_seg,
  input wire logic [15:0] op_sel,
  input wire logic [15:0] op_aux,
  input wire logic io_bitmap_ok,
  // Fetched descriptor
  input wire logic desc_ok,
  input wire logic desc_s,
  input wire logic [3:0] desc_type,
  input wire logic [1:0] desc_dpl,
  input wire logic desc_present,
  input wire logic [31:0] desc_limit,
  input wire logic [7:0] desc_ar,
  // Answer
  output logic res_valid,
  output logic res_fault,
  output logic [7:0] res_vector,
  output logic res_zf,
  output logic [31:0] res_value,
  output logic if_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [1:0] current_priv_level;
  logic [1:0] io_priv_field;
  logic tss32;
  logic v86;
  logic [15:0] seg_sel [SPC_NUM_SEG];
  logic [7:0] seg_ar [SPC_NUM_SEG];
  logic [7:0] last_vec;
  logic last_fault;
  logic last_zf;

  // ****************************************************************
  // Level arithmetic
  // ****************************************************************
  spc_op_t op;
  logic [1:0] cpl_eff;
  logic [1:0] requested_priv_level;
  logic [1:0] effective_priv_level;
  logic is_code;
  logic conf;
  logic readable;
  logic writable;
  logic data_priv_ok;
  logic io_free;
  logic [1:0] adjust_requested_level_instr_lvl;

  assign op = spc_op_t'(op_code);
  assign cpl_eff = v86 ? SPC_LEVEL_V86 : current_priv_level;
  assign requested_priv_level = op_sel[1:0];
  assign effective_priv_level = (requested_priv_level > cpl_eff) ?
    requested_priv_level : cpl_eff;
  assign is_code = desc_type[SPC_TYPE_CODE_BIT];
  assign conf = is_code & desc_type[SPC_TYPE_CONF_BIT];
  assign readable = ~is_code | desc_type[SPC_TYPE_RW_BIT];
  assign writable = ~is_code & desc_type[SPC_TYPE_RW_BIT];
  // Conforming readable code bypasses the level compare
  assign data_priv_ok = (conf & readable) |
    (effective_priv_level <= desc_dpl);
  assign io_free = cpl_eff <= io_priv_field;
  assign adjust_requested_level_instr_lvl = (op_aux[1:0] > requested_priv_level) ?
    op_aux[1:0] : requested_priv_level;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  logic next_fault;
  logic [7:0] next_vec;
  logic next_zf;
  logic [31:0] next_value;
  logic seg_we;

  always_comb begin
    next_fault = 1'b0;
    next_vec = SPC_VEC_NONE;
    next_zf = 1'b0;
    next_value = 32'h0000_0000;
    seg_we = 1'b0;
    unique case (op)
      SPC_OP_LOAD_DATA: begin
        if (!desc_ok || !desc_s || !readable || !data_priv_ok ||
            effective_priv_level < cpl_eff) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_GP;
        end else if (!desc_present) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_SEG_NP;
        end else begin
          seg_we = 1'b1;
        end
      end
      SPC_OP_LOAD_STACK: begin
        // No conforming exemption and no level slack here
        if (!desc_ok || !desc_s || !writable ||
            desc_dpl != cpl_eff || requested_priv_level != cpl_eff) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_GP;
        end else if (!desc_present) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_STACK;
        end else begin
          seg_we = 1'b1;
        end
      end
      SPC_OP_IO: begin
        // Older task format has no bitmap to fall back on
        if (!io_free && (!tss32 || !io_bitmap_ok)) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_GP;
        end
      end
      SPC_OP_CLI, SPC_OP_STI: begin
        if (!io_free) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_GP;
        end
      end
      SPC_OP_LOCK: begin
        next_fault = 1'b0;
      end
      SPC_OP_FLAGS_LOAD: begin
        next_fault = 1'b0;
      end
      SPC_OP_ADJUST_REQUESTED_LEVEL_INSTR: begin
        next_value = {16'h0000, op_sel[15:2], adjust_requested_level_instr_lvl};
        next_zf = adjust_requested_level_instr_lvl != requested_priv_level;
      end
      SPC_OP_VERIFY_READ_INSTR: begin
        next_zf = desc_ok & desc_s & readable & data_priv_ok;
      end
      SPC_OP_VERIFY_WRITE_INSTR: begin
        next_zf = desc_ok & desc_s & writable &
          (effective_priv_level <= desc_dpl);
      end
      SPC_OP_LSL: begin
        next_zf = desc_ok & desc_s & data_priv_ok;
        next_value = next_zf ? desc_limit : 32'h0000_0000;
      end
      SPC_OP_LAR: begin
        next_zf = desc_ok & desc_s & data_priv_ok;
        next_value = next_zf ? {24'h00_0000, desc_ar} : 32'h0000_0000;
      end
      SPC_OP_GATE: begin
        next_zf = desc_ok & desc_s & is_code &
          (desc_dpl != current_priv_level);
        next_value = {30'h0000_0000, desc_dpl};
      end
      SPC_OP_CALL: begin
        // Gates are handled elsewhere; direct calls only
        if (!desc_ok || !desc_s || !is_code || cpl_eff < desc_dpl) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_GP;
        end else if (!desc_present) begin
          next_fault = 1'b1;
          next_vec = SPC_VEC_SEG_NP;
        end
      end
      default: begin
        next_fault = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Answer registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      res_valid <= 1'b0;
      res_fault <= 1'b0;
      res_vector <= SPC_VEC_NONE;
      res_zf <= 1'b0;
      res_value <= 32'h0000_0000;
    end else begin
      // Zero between pulses so no stale answer lingers
      res_valid <= op_valid;
      res_fault <= op_valid & next_fault;
      res_vector <= op_valid ? next_vec : SPC_VEC_NONE;
      res_zf <= op_valid & next_zf;
      res_value <= op_valid ? next_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      last_vec <= SPC_VEC_NONE;
      last_fault <= 1'b0;
      last_zf <= 1'b0;
    end else if (op_valid) begin
      // Kept for software to poll after the pulse has gone
      last_vec <= next_vec;
      last_fault <= next_fault;
      last_zf <= next_zf;
    end
  end

  // ****************************************************************
  // Privilege level
  // ****************************************************************
  // Software cannot write the level; only a gate transfer moves it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      current_priv_level <= SPC_RST_CPL;
    end else if (op_valid && op == SPC_OP_GATE && next_zf) begin
      current_priv_level <= desc_dpl;
    end
  end

  // ****************************************************************
  // Segment registers and descriptor cache
  // ****************************************************************
  logic [2:0] seg_idx;

  // Stack slot sits after the four data slots
  assign seg_idx = (op == SPC_OP_LOAD_STACK) ?
    3'(SPC_STACK_IDX) : {1'b0, op_seg};

  generate
    for (genvar i = 0; i < SPC_NUM_SEG; i++) begin : g_seg
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          seg_sel[i] <= 16'h0000;
          seg_ar[i] <= 8'h00;
        end else if (op_valid && seg_we && seg_idx == 3'(i)) begin
          seg_sel[i] <= op_sel;
          seg_ar[i] <= desc_ar;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // One wait state: a write is taken on the edge with wait low; read data is latched on the edge before, with wait high
  logic bus_req;
  logic bus_wr;
  logic [5:0] word;

  assign bus_req = avs_read | avs_write;
  assign bus_wr = avs_write & ~avs_waitrequest;
  assign word = avs_address[7:2];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      io_priv_field <= SPC_RST_IO_PRIV_FIELD;
      tss32 <= 1'b0;
      v86 <= 1'b0;
    end else if (bus_wr && avs_address == SPC_OFF_CTRL &&
                 avs_byteenable[0]) begin
      io_priv_field <= avs_writedata[SPC_CTRL_IO_PRIV_FIELD_LSB +: 2];
      tss32 <= avs_writedata[SPC_CTRL_TSS32_BIT];
      v86 <= avs_writedata[SPC_CTRL_V86_BIT];
    end
  end

  // An allowed CLI/STI, or any flags load, takes priority over a software write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      if_flag <= 1'b0;
    end else if (op_valid && io_free &&
                 (op == SPC_OP_CLI || op == SPC_OP_STI)) begin
      if_flag <= op == SPC_OP_STI;
    end else if (op_valid && op == SPC_OP_FLAGS_LOAD) begin
      if (io_free) begin
        if_flag <= op_aux[SPC_FLAGS_IF_BIT];
      end
    end else if (bus_wr && avs_address == SPC_OFF_CTRL &&
                 avs_byteenable[0]) begin
      if_flag <= avs_writedata[SPC_CTRL_IF_BIT];
    end
  end

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == SPC_OFF_CTRL) begin
      rd_mux[SPC_CTRL_CPL_LSB +: 2] = cpl_eff;
      rd_mux[SPC_CTRL_IO_PRIV_FIELD_LSB +: 2] = io_priv_field;
      rd_mux[SPC_CTRL_IF_BIT] = if_flag;
      rd_mux[SPC_CTRL_TSS32_BIT] = tss32;
      rd_mux[SPC_CTRL_V86_BIT] = v86;
    end else if (avs_address == SPC_OFF_STATUS) begin
      rd_mux[7:0] = last_vec;
      rd_mux[SPC_STAT_FAULT_BIT] = last_fault;
      rd_mux[SPC_STAT_ZF_BIT] = last_zf;
    end else begin
      // Words outside the table read zero
      for (int i = 0; i < SPC_NUM_SEG; i++) begin
        if (word == SPC_OFF_SEG0[7:2] + 6'(i)) begin
          rd_mux[15:0] = seg_sel[i];
          rd_mux[SPC_SEG_AR_LSB +: 8] = seg_ar[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule : spc_checker

// ===== tb/spc_checker_sva.sv
// Purpose: port assertions for the segment privilege checker
// Assumes: every answer comes one cycle after its request
// Notes: level state is internal, so answers are tied to inputs
`timescale 1ns/1ps
module spc_checker_sva
  import spc_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Request and descriptor
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [15:0] op_sel,
  input wire logic [15:0] op_aux,
  input wire logic desc_ok,
  input wire logic desc_s,
  input wire logic [3:0] desc_type,
  input wire logic [1:0] desc_dpl,
  input wire logic desc_present,
  input wire logic [31:0] desc_limit,
  // Answer
  input wire logic res_valid,
  input wire logic res_fault,
  input wire logic [7:0] res_vector,
  input wire logic res_zf,
  input wire logic [31:0] res_value,
  input wire logic if_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [1:0] mx;
  logic up;
  logic ld;
  // Adjust-level result, compared one cycle later
  assign up = op_aux[1:0] > op_sel[1:0];
  assign mx = up ? op_aux[1:0] : op_sel[1:0];
  assign ld = op_valid && op_code == SPC_OP_LOAD_DATA;
  ans_pulse_a: assert property (res_valid == $past(op_valid))
    else $error("answer pulse wrong");
  fault_vec_a: assert property (
    res_valid |-> res_fault == (res_vector != SPC_VEC_NONE))
    else $error("fault and vector disagree");
  lock_free_a: assert property (
    op_valid && op_code == SPC_OP_LOCK |=> !res_fault)
    else $error("lock prefix faulted");
  adjust_requested_level_instr_max_a: assert property (
    op_valid && op_code == SPC_OP_ADJUST_REQUESTED_LEVEL_INSTR |=>
    res_value[1:0] == $past(mx) && res_zf == $past(up))
    else $error("adjust level wrong");
  stk_lvl_a: assert property (
    op_valid && op_code == SPC_OP_LOAD_STACK && desc_dpl != op_sel[1:0]
    |=> res_vector == SPC_VEC_GP) else $error("stack level not refused");
  data_type_a: assert property (
    ld && (!desc_s || desc_type[3] && !desc_type[1])
    |=> res_vector == SPC_VEC_GP) else $error("bad data type accepted");
  conf_ok_a: assert property (
    ld && desc_ok && desc_s && desc_type[3:1] == 3'h7 && desc_present
    |=> !res_fault) else $error("conforming code refused");
  lsl_val_a: assert property (
    op_valid && op_code == SPC_OP_LSL ##1 res_zf
    |-> res_value == $past(desc_limit)) else $error("limit value wrong");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus wait cycle wrong");
  if_hold_a: assert property (
    !op_valid && !avs_write |=> $stable(if_flag))
    else $error("interrupt flag moved");
endmodule : spc_checker_sva

bind spc_checker spc_checker_sva u_spc_checker_sva (.*);

// ===== tb/spc_desc_model.sv
// Purpose: descriptor fetch and port bitmap side of the checker
// Assumes: fields only matter while op_valid is high
// Notes: outside a request every field shows its inverse, save the fixed upper 24 bits of desc_limit
`timescale 1ns/1ps
module spc_desc_model (
  // Request
  input wire logic op_valid,
  input wire logic [15:0] op_sel,
  input wire logic [15:0] op_aux,
  // Descriptor
  output logic io_bitmap_ok,
  output logic desc_ok,
  output logic desc_s,
  output logic [3:0] desc_type,
  output logic [1:0] desc_dpl,
  output logic desc_present,
  output logic [31:0] desc_limit,
  output logic [7:0] desc_ar
);
  // Rights byte per table slot: present, level, segment, type
  localparam logic [7:0] TBL [8] = '{8'hD2, 8'hD0, 8'h9E, 8'hD8,
    8'h82, 8'h52, 8'hFA, 8'hF2};
  logic [7:0] e;
  always_comb begin
    e = TBL[op_sel[5:3]] ^ {8{!op_valid}};
  end
  assign desc_ar = e;
  assign {desc_present, desc_dpl, desc_s, desc_type} = e;
  assign desc_limit = {24'h000FFF, e};
  assign desc_ok = (op_sel[15:6] == 10'h000) ^ !op_valid;
  // Port permitted when its low address bit is set
  assign io_bitmap_ok = op_aux[0] ^ !op_valid;
endmodule : spc_desc_model

// ===== tb/segment_privilege_checker_test.sv
// Purpose: self-checking bench for the segment privilege checker
// Assumes: bus answers after one wait cycle, ops one cycle later
// Notes: descriptors come from the fixed table of the model
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module segment_privilege_checker_test import spc_pkg::*;;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata, rval;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, op_valid = 1'h0;
  logic [3:0] op_code = 4'h0;
  logic [1:0] op_seg = 2'h1;
  logic [15:0] op_sel = 16'h0, op_aux = 16'h0;
  logic io_bitmap_ok, desc_ok, desc_s, desc_present;
  logic [3:0] desc_type;
  logic [1:0] desc_dpl;
  logic [31:0] desc_limit, res_value;
  logic [7:0] desc_ar, res_vector;
  logic res_valid, res_fault, res_zf, if_flag;
  int err_total = 0;
  int checks = 0;
  logic [15:0] dsel [7] = '{16'h0002, 16'h0003, 16'h0013, 16'h0018,
    16'h0020, 16'h0008, 16'h002A};
  logic [7:0] dvec [7] = '{8'h00, 8'h0D, 8'h00, 8'h0D, 8'h0D, 8'h00, 8'h0B};
  logic [15:0] ssel [5] = '{16'h0002, 16'h0001, 16'h000A, 16'h002A,
    16'h0038};
  logic [7:0] svec [5] = '{8'h00, 8'h0D, 8'h0D, 8'h0C, 8'h0D};
  always #2 mclk = ~mclk;
  spc_checker u_spc_checker (.*);
  spc_desc_model u_spc_desc_model (.*);

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 16);
    if (n >= 16) begin
      err_total++;
      end_of_test();
    end
    rdata = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK("readdata", e, rdata)
  endtask : rd

  task automatic op(input spc_op_t c, input logic [15:0] s,
                    input logic [15:0] x, input logic [7:0] v,
                    input logic z);
    @(posedge mclk);
    op_valid <= 1'h1;
    op_code <= c;
    op_sel <= s;
    op_aux <= x;
    @(posedge mclk);
    op_valid <= 1'h0;
    #1;
    `CHK("res_valid", 1'h1, res_valid)
    `CHK("res_fault", v != 8'h00, res_fault)
    `CHK("res_vector", v, res_vector)
    `CHK("res_zf", z, res_zf)
    rval = res_value;
  endtask : op

  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    rd(SPC_OFF_CTRL, 32'h0);
    rd(SPC_OFF_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    `CHK("if_flag", 1'h0, if_flag)
    op(SPC_OP_IO, 16'h0, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_FLAGS_LOAD, 16'h0, 16'h0200, 8'h00, 1'h0);
    `CHK("if_flag", 1'h1, if_flag)
    op(SPC_OP_GATE, 16'h0030, 16'h0, 8'h00, 1'h1);
    rd(SPC_OFF_CTRL, 32'h13);
    bus(1'h1, SPC_OFF_CTRL, 32'h11);
    rd(SPC_OFF_CTRL, 32'h13);
    $display("test level done");
    op(SPC_OP_IO, 16'h0, 16'h1, 8'h0D, 1'h0);
    bus(1'h1, SPC_OFF_CTRL, 32'h30);
    op(SPC_OP_IO, 16'h0, 16'h1, 8'h00, 1'h0);
    op(SPC_OP_IO, 16'h0, 16'h0, 8'h0D, 1'h0);
    op(SPC_OP_CLI, 16'h0, 16'h0, 8'h0D, 1'h0);
    op(SPC_OP_STI, 16'h0, 16'h0, 8'h0D, 1'h0);
    op(SPC_OP_LOCK, 16'h0, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_NOP, 16'h0, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_FLAGS_LOAD, 16'h0, 16'h0, 8'h00, 1'h0);
    `CHK("if_flag", 1'h1, if_flag)
    bus(1'h1, SPC_OFF_CTRL, 32'h3C);
    op(SPC_OP_IO, 16'h0, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_CLI, 16'h0, 16'h0, 8'h00, 1'h0);
    `CHK("if_flag", 1'h0, if_flag)
    op(SPC_OP_STI, 16'h0, 16'h0, 8'h00, 1'h0);
    `CHK("if_flag", 1'h1, if_flag)
    $display("test io done");
    op(SPC_OP_GATE, 16'h0018, 16'h0, 8'h00, 1'h1);
    `CHK("level", 32'h2, rval)
    rd(SPC_OFF_CTRL, 32'h3E);
    avs_byteenable <= 4'hE;
    bus(1'h1, SPC_OFF_CTRL, 32'h00);
    avs_byteenable <= 4'hF;
    rd(SPC_OFF_CTRL, 32'h3E);
    op(SPC_OP_FLAGS_LOAD, 16'h0, 16'h0, 8'h00, 1'h0);
    `CHK("if_flag", 1'h0, if_flag)
    for (int i = 0; i < 7; i++) begin
      op(SPC_OP_LOAD_DATA, dsel[i], 16'h0, dvec[i], 1'h0);
    end
    rd(8'h14, 32'h00D00008);
    op_seg <= 2'h3;
    op(SPC_OP_LOAD_DATA, 16'h0013, 16'h0, 8'h00, 1'h0);
    rd(8'h1C, 32'h009E0013);
    for (int i = 0; i < 5; i++) begin
      op(SPC_OP_LOAD_STACK, ssel[i], 16'h0, svec[i], 1'h0);
    end
    rd(8'h20, 32'h00D20002);
    rd(SPC_OFF_STATUS, 32'h10D);
    $display("test loads done");
    op(SPC_OP_ADJUST_REQUESTED_LEVEL_INSTR, 16'h0001, 16'h0002, 8'h00, 1'h1);
    `CHK("value", 16'h0002, rval[15:0])
    op(SPC_OP_ADJUST_REQUESTED_LEVEL_INSTR, 16'h0003, 16'h0001, 8'h00, 1'h0);
    `CHK("value", 16'h0003, rval[15:0])
    op(SPC_OP_VERIFY_READ_INSTR, 16'h0002, 16'h0, 8'h00, 1'h1);
    op(SPC_OP_VERIFY_READ_INSTR, 16'h0003, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_VERIFY_READ_INSTR, 16'h0013, 16'h0, 8'h00, 1'h1);
    op(SPC_OP_VERIFY_WRITE_INSTR, 16'h0008, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_VERIFY_WRITE_INSTR, 16'h0002, 16'h0, 8'h00, 1'h1);
    op(SPC_OP_LSL, 16'h0002, 16'h0, 8'h00, 1'h1);
    `CHK("limit", 32'h000FFFD2, rval)
    op(SPC_OP_LSL, 16'h0003, 16'h0, 8'h00, 1'h0);
    op(SPC_OP_LAR, 16'h0030, 16'h0, 8'h00, 1'h1);
    `CHK("rights", 8'hFA, rval[7:0])
    op(SPC_OP_CALL, 16'h0030, 16'h0, 8'h0D, 1'h0);
    op(SPC_OP_CALL, 16'h0018, 16'h0, 8'h00, 1'h0);
    $display("test pointer done");
    bus(1'h1, SPC_OFF_CTRL, 32'h40);
    rd(SPC_OFF_CTRL, 32'h43);
    op(SPC_OP_IO, 16'h0, 16'h1, 8'h0D, 1'h0);
    $display("test v86 done");
    end_of_test();
  end
endmodule : segment_privilege_checker_test
